// ==== logic/pgms_params.svh ====
// timing and field constants for the pack gauge mode scheduler
`ifndef PGMS_PARAMS_SVH
`define PGMS_PARAMS_SVH
`define PGMS_CLK_HZ          25000000
`define PGMS_NORMAL_MS       250
`define PGMS_NORMAL_CYC      ((`PGMS_CLK_HZ / 1000) * `PGMS_NORMAL_MS)
`define PGMS_BUSOFF_MS       2000
`define PGMS_BUSOFF_CYC      ((`PGMS_CLK_HZ / 1000) * `PGMS_BUSOFF_MS)
`define PGMS_RESUME_US       1000
`define PGMS_RESUME_CYC      ((`PGMS_CLK_HZ / 1000000) * `PGMS_RESUME_US)
`define PGMS_CAL_CYC_DEF     64
`define PGMS_CNT_W           32
`define PGMS_CELLS           4
`define PGMS_CELL_W          16
`define PGMS_LED_MAX         5
`define PGMS_TEMP_N          5
`define PGMS_PCT_FULL        8'h64
`endif

// ==== logic/pgms_pkg.sv ====
// types for the pack gauge mode scheduler
package pgms_pkg;
	typedef enum logic [4:0]
	{
		PGMS_NORMAL   = 5'h01,
		PGMS_SLEEP    = 5'h02,
		PGMS_CAL      = 5'h04,
		PGMS_BUSOFF   = 5'h08,
		PGMS_SHUTDOWN = 5'h10
	} pgms_mode_t;
endpackage

// ==== logic/pgms_top.sv ====
// measurement and power-mode scheduler for a battery-pack monitor
`timescale 1ns/1ps
`include "pgms_params.svh"
// Function
// - refresh each cell voltage every cycle (quarter second in normal mode), scaled and calibrated.
// - enter bus-off after both bus lines stay low two seconds.
// - leave bus-off when clock or data line goes high, or on shutdown request.
// - bus ready again within one millisecond after bus-off clears.
// - normal mode runs one cycle every 250 ms, idle between.
// - sleep mode runs cycles at a configurable interval, idle between.
// - leave sleep on detected current flow or fault.
// - shutdown mode does no measurement, computation or communication.
// - drive 3, 4 or 5 segment LED bar: capacity or failure code.
// - five temperature inputs, each enabled and assigned to cell or switch.
// - two separate thermistor profiles, for cell and switch temperature.
// - SMBus 1.1 link with optional master mode and error checking.
// - host-started hash authentication; host challenges and checks response.
// - both bus lines low in normal mode: run offset calibration, then sleep.
module pgms_top
	import pgms_pkg::*;
#(
	parameter int NORMAL_CYC = `PGMS_NORMAL_CYC,
	parameter int BUSOFF_CYC = `PGMS_BUSOFF_CYC,
	parameter int CAL_CYC    = `PGMS_CAL_CYC_DEF
)
(
	// clock and reset
	input  wire logic                         sys_clk_i,
	input  wire logic                         rst_b_i,
	// bus pins, open drain sensing
	input  wire logic                         bus_clock_pin_i,
	input  wire logic                         bus_data_pin_i,
	// power control
	input  wire logic                         shutdown_req_i,
	input  wire logic                         sleep_req_i,
	input  wire logic [`PGMS_CNT_W-1:0]       sleep_interval_i,
	input  wire logic                         current_flow_i,
	input  wire logic                         fault_i,
	// cell conversion
	input  wire logic [`PGMS_CELLS*`PGMS_CELL_W-1:0] cell_raw_i,
	input  wire logic [`PGMS_CELL_W-1:0]      cell_gain_i,
	input  wire logic [`PGMS_CELL_W-1:0]      cell_offset_i,
	// temperature selection
	input  wire logic [`PGMS_TEMP_N-1:0]      temp_enable_i,
	input  wire logic [`PGMS_TEMP_N-1:0]      temp_is_fet_i,
	input  wire logic [`PGMS_TEMP_N*8-1:0]    temp_raw_i,
	input  wire logic [7:0]                   cell_profile_off_i,
	input  wire logic [7:0]                   fet_profile_off_i,
	// led display
	input  wire logic [2:0]                   led_count_i,
	input  wire logic [7:0]                   capacity_pct_i,
	input  wire logic                         pf_active_i,
	input  wire logic [`PGMS_LED_MAX-1:0]     permanent_failure_code_i,
	// link options
	input  wire logic                         master_en_i,
	input  wire logic                         pec_en_i,
	// scheduler outputs
	output logic                              cycle_strobe_o,
	output logic                              low_power_o,
	output logic                              cal_busy_o,
	output logic                              bus_off_o,
	output logic                              bus_ready_o,
	output logic                              master_active_o,
	output logic                              pec_active_o,
	output logic                              auth_allow_o,
	output pgms_mode_t                        mode_o,
	output logic [`PGMS_CELLS*`PGMS_CELL_W-1:0] cell_mv_o,
	output logic [`PGMS_TEMP_N*8-1:0]         temp_o,
	output logic [`PGMS_TEMP_N-1:0]           temp_valid_o,
	output logic [`PGMS_TEMP_N-1:0]           temp_fet_o,
	output logic [`PGMS_LED_MAX-1:0]          led_o
);

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers
logic [1:0] clk_sync;
logic [1:0] dat_sync;
always_ff @(posedge sys_clk_i or negedge rst_b_i)
	if (!rst_b_i)
	begin
		clk_sync <= 2'h3;
		dat_sync <= 2'h3;
	end
	else
	begin
		clk_sync <= {clk_sync[0], bus_clock_pin_i};
		dat_sync <= {dat_sync[0], bus_data_pin_i};
	end
logic both_low;
assign both_low = !clk_sync[1] && !dat_sync[1];

////////////////////////////////////////////////////////////////////////////////
// bus low timer
logic [`PGMS_CNT_W-1:0] low_cnt;
logic                   low_long;
always_ff @(posedge sys_clk_i or negedge rst_b_i)
	if (!rst_b_i)
		low_cnt <= '0;
	else if (!both_low)
		low_cnt <= '0;
	else if (!low_long)
		low_cnt <= low_cnt + 1'b1;
assign low_long = (low_cnt >= (BUSOFF_CYC - 1));

////////////////////////////////////////////////////////////////////////////////
// mode machine
pgms_mode_t mode;
pgms_mode_t prior;
pgms_mode_t next_mode;
logic [`PGMS_CNT_W-1:0] cal_cnt;
logic                   low_seen;
always_comb
begin
	next_mode = mode;
	unique case (mode)
		PGMS_NORMAL:
			if (shutdown_req_i)
				next_mode = PGMS_SHUTDOWN;
			else if (low_long)
				next_mode = PGMS_BUSOFF;
			else if (both_low && !low_seen)
				next_mode = PGMS_CAL;
			else if (sleep_req_i && !current_flow_i && !fault_i)
				next_mode = PGMS_SLEEP;
		PGMS_SLEEP:
			if (shutdown_req_i)
				next_mode = PGMS_SHUTDOWN;
			else if (current_flow_i || fault_i)
				next_mode = PGMS_NORMAL;
			else if (low_long)
				next_mode = PGMS_BUSOFF;
		PGMS_CAL:
			if (shutdown_req_i)
				next_mode = PGMS_SHUTDOWN;
			else if (cal_cnt >= (CAL_CYC - 1))
				next_mode = PGMS_SLEEP;
		PGMS_BUSOFF:
			if (shutdown_req_i)
				next_mode = PGMS_SHUTDOWN;
			else if (!both_low)
				next_mode = prior;
		PGMS_SHUTDOWN:
			next_mode = PGMS_SHUTDOWN;
		default:
			next_mode = PGMS_NORMAL;
	endcase
end
always_ff @(posedge sys_clk_i or negedge rst_b_i)
	if (!rst_b_i)
		mode <= PGMS_NORMAL;
	else
		mode <= next_mode;
always_ff @(posedge sys_clk_i or negedge rst_b_i)
	if (!rst_b_i)
		prior <= PGMS_NORMAL;
	else if (next_mode == PGMS_BUSOFF && mode != PGMS_BUSOFF)
		prior <= (mode == PGMS_SLEEP) ? PGMS_SLEEP : PGMS_NORMAL;
always_ff @(posedge sys_clk_i or negedge rst_b_i)
	if (!rst_b_i)
		cal_cnt <= '0;
	else if (mode == PGMS_CAL)
		cal_cnt <= cal_cnt + 1'b1;
	else
		cal_cnt <= '0;
// calibrate once per low episode, re-armed when a line rises
always_ff @(posedge sys_clk_i or negedge rst_b_i)
	if (!rst_b_i)
		low_seen <= 1'b0;
	else if (!both_low)
		low_seen <= 1'b0;
	else if (mode == PGMS_CAL)
		low_seen <= 1'b1;

////////////////////////////////////////////////////////////////////////////////
// cycle timer
logic [`PGMS_CNT_W-1:0] per_cnt;
logic [`PGMS_CNT_W-1:0] period;
logic                   run_mode;
assign run_mode = (mode == PGMS_NORMAL) || (mode == PGMS_SLEEP);
// a zero sleep interval would never wrap, so it runs a cycle on every clock
always_comb
begin
	if (mode == PGMS_SLEEP)
		period = (sleep_interval_i == '0) ? `PGMS_CNT_W'(1) : sleep_interval_i;
	else
		period = `PGMS_CNT_W'(NORMAL_CYC);
end
logic tick;
assign tick = run_mode && (per_cnt >= period - 1'b1);
always_ff @(posedge sys_clk_i or negedge rst_b_i)
	if (!rst_b_i)
		per_cnt <= '0;
	else if (!run_mode || tick)
		per_cnt <= '0;
	else
		per_cnt <= per_cnt + 1'b1;
always_ff @(posedge sys_clk_i or negedge rst_b_i)
	if (!rst_b_i)
	begin
		cycle_strobe_o <= 1'b0;
		low_power_o    <= 1'b0;
	end
	else
	begin
		cycle_strobe_o <= tick;
		low_power_o    <= !tick;
	end

////////////////////////////////////////////////////////////////////////////////
// cell voltage refresh
genvar gi;
generate
	for (gi = 0; gi < `PGMS_CELLS; gi++)
	begin : g_cell
		logic [2*`PGMS_CELL_W-1:0] prod;
		assign prod = cell_raw_i[gi*`PGMS_CELL_W +: `PGMS_CELL_W] * cell_gain_i;
		always_ff @(posedge sys_clk_i or negedge rst_b_i)
			if (!rst_b_i)
				cell_mv_o[gi*`PGMS_CELL_W +: `PGMS_CELL_W] <= '0;
			else if (tick)
				// offset sum wraps at the field width, no saturation
				cell_mv_o[gi*`PGMS_CELL_W +: `PGMS_CELL_W] <=
					`PGMS_CELL_W'(prod[2*`PGMS_CELL_W-1 -: `PGMS_CELL_W] + cell_offset_i);
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// temperature selection with per-profile offsets
generate
	for (gi = 0; gi < `PGMS_TEMP_N; gi++)
	begin : g_temp
		always_ff @(posedge sys_clk_i or negedge rst_b_i)
			if (!rst_b_i)
			begin
				temp_o[gi*8 +: 8]  <= '0;
				temp_valid_o[gi]   <= 1'b0;
				temp_fet_o[gi]     <= 1'b0;
			end
			else if (tick)
			begin
				temp_o[gi*8 +: 8] <= 8'(temp_raw_i[gi*8 +: 8] +
					(temp_is_fet_i[gi] ? fet_profile_off_i : cell_profile_off_i));
				temp_valid_o[gi]  <= temp_enable_i[gi];
				temp_fet_o[gi]    <= temp_is_fet_i[gi];
			end
	end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// led bar
logic [2:0]  seg_n;
logic [10:0] lit_prod;
logic [2:0]  lit;
logic [`PGMS_LED_MAX-1:0] seg_mask;
assign seg_n    = (led_count_i < 3'h3) ? 3'h3 : ((led_count_i > 3'h5) ? 3'h5 : led_count_i);
assign lit_prod = 11'((capacity_pct_i * seg_n + (`PGMS_PCT_FULL - 1)) / `PGMS_PCT_FULL);
assign lit      = (lit_prod > 11'(seg_n)) ? seg_n : lit_prod[2:0];
assign seg_mask = `PGMS_LED_MAX'((6'h01 << seg_n) - 6'h01);
always_ff @(posedge sys_clk_i or negedge rst_b_i)
	if (!rst_b_i)
		led_o <= '0;
	else if (mode == PGMS_SHUTDOWN)
		led_o <= '0;
	else if (pf_active_i)
		led_o <= permanent_failure_code_i & seg_mask;
	else
		led_o <= `PGMS_LED_MAX'((6'h01 << lit) - 6'h01);

////////////////////////////////////////////////////////////////////////////////
// bus readiness after bus-off
logic [`PGMS_CNT_W-1:0] res_cnt;
always_ff @(posedge sys_clk_i or negedge rst_b_i)
	if (!rst_b_i)
		res_cnt <= '0;
	else if (mode == PGMS_BUSOFF && next_mode != PGMS_BUSOFF)
		res_cnt <= `PGMS_CNT_W'(`PGMS_RESUME_CYC - 1);
	else if (res_cnt != '0)
		res_cnt <= res_cnt - 1'b1;
always_ff @(posedge sys_clk_i or negedge rst_b_i)
	if (!rst_b_i)
	begin
		bus_ready_o     <= 1'b1;
		bus_off_o       <= 1'b0;
		master_active_o <= 1'b0;
		pec_active_o    <= 1'b0;
		auth_allow_o    <= 1'b0;
		cal_busy_o      <= 1'b0;
		mode_o          <= PGMS_NORMAL;
	end
	else
	begin
		bus_ready_o     <= run_mode && (res_cnt == '0);
		bus_off_o       <= (mode == PGMS_BUSOFF);
		master_active_o <= master_en_i && run_mode;
		pec_active_o    <= pec_en_i && run_mode;
		auth_allow_o    <= run_mode && (res_cnt == '0);
		cal_busy_o      <= (mode == PGMS_CAL);
		mode_o          <= mode;
	end

endmodule

// ==== sim/pgms_host_model.sv ====
// host side model driving the two bus lines
`timescale 1ns/1ps
module pgms_host_model
(
	// clock and control
	input  wire logic sys_clk_i,
	input  wire logic attach_i,
	// bus lines as the device senses them
	output logic      bus_clock_o,
	output logic      bus_data_o
);
	initial
	begin
		bus_clock_o = 1'b1;
		bus_data_o = 1'b1;
	end
	// idle high while attached, released lines fall to the pull-down level
	always @(posedge sys_clk_i)
	begin
		bus_clock_o <= attach_i;
		bus_data_o <= attach_i;
	end
endmodule

// ==== sim/pgms_top_chk.sv ====
// port assertions for the pack gauge mode scheduler
`timescale 1ns/1ps
module pgms_chk
	import pgms_pkg::*;
#(
	parameter int NORMAL_CYC = 50,
	parameter int BUSOFF_CYC = 200
)
(
	// watched ports
	input wire logic       sys_clk_i,
	input wire logic       rst_b_i,
	input wire logic       bus_clock_pin_i,
	input wire logic       bus_data_pin_i,
	input wire logic       current_flow_i,
	input wire logic       fault_i,
	input wire logic       cycle_strobe_o,
	input wire logic       low_power_o,
	input wire logic       bus_off_o,
	input wire logic       bus_ready_o,
	input wire pgms_mode_t mode_o,
	input wire logic [4:0] led_o
);
	localparam int RESUME_MAX = 25005;
	logic [31:0] gap;
	logic [31:0] low_cnt;
	logic [31:0] nrdy;
	logic        pn;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			gap <= '0;
			low_cnt <= '0;
			nrdy <= '0;
			pn <= 1'b0;
		end
		else
		begin
			gap <= cycle_strobe_o ? 32'h1 : gap + 32'h1;
			pn <= (mode_o == PGMS_NORMAL) && (pn || cycle_strobe_o);
			low_cnt <= (bus_clock_pin_i || bus_data_pin_i) ? '0 : low_cnt + 32'h1;
			nrdy <= (bus_ready_o || bus_off_o || mode_o == PGMS_SHUTDOWN) ? '0 : nrdy + 32'h1;
		end
	end
	sequence s_cal_run;
		(mode_o == PGMS_CAL)[*7];
	endsequence
	sequence s_off_low;
		(bus_off_o && !bus_clock_pin_i && !bus_data_pin_i)[*4];
	endsequence
	AST_LOW_POWER: assert property (mode_o == PGMS_NORMAL && cycle_strobe_o |-> !low_power_o ##1 low_power_o)
		else $error("low power not left for one cycle");
	AST_NORMAL_PERIOD: assert property (cycle_strobe_o && pn |-> gap == NORMAL_CYC)
		else $error("normal cycle spacing wrong");
	AST_SHUTDOWN_QUIET: assert property (mode_o == PGMS_SHUTDOWN |-> !cycle_strobe_o && !bus_ready_o && led_o == 5'h00)
		else $error("activity in shutdown");
	AST_BUSOFF_ENTRY: assert property ($rose(bus_off_o) |-> low_cnt >= BUSOFF_CYC)
		else $error("bus off too early");
	AST_BUSOFF_DUE: assert property (low_cnt == BUSOFF_CYC + 8 && mode_o != PGMS_SHUTDOWN |-> bus_off_o)
		else $error("bus off missing");
	AST_BUSOFF_HOLD: assert property (s_off_low |=> bus_off_o)
		else $error("bus off left with lines low");
	AST_BUSOFF_EXIT: assert property (bus_off_o && (bus_clock_pin_i || bus_data_pin_i) |-> ##[1:4] !bus_off_o)
		else $error("bus off not cleared");
	AST_RESUME: assert property (nrdy <= RESUME_MAX)
		else $error("bus not ready in time");
	AST_WAKE: assert property (mode_o == PGMS_SLEEP && (current_flow_i || fault_i) |-> ##[1:3] mode_o != PGMS_SLEEP)
		else $error("no wake from sleep");
	AST_CAL_TO_SLEEP: assert property ($rose(mode_o == PGMS_CAL) |-> s_cal_run ##[1:3] mode_o == PGMS_SLEEP)
		else $error("calibration not followed by sleep");
endmodule
bind pgms_top pgms_chk #(.NORMAL_CYC(NORMAL_CYC), .BUSOFF_CYC(BUSOFF_CYC)) u_chk
(
	.sys_clk_i(sys_clk_i),
	.rst_b_i(rst_b_i),
	.bus_clock_pin_i(bus_clock_pin_i),
	.bus_data_pin_i(bus_data_pin_i),
	.current_flow_i(current_flow_i),
	.fault_i(fault_i),
	.cycle_strobe_o(cycle_strobe_o),
	.low_power_o(low_power_o),
	.bus_off_o(bus_off_o),
	.bus_ready_o(bus_ready_o),
	.mode_o(mode_o),
	.led_o(led_o)
);

// ==== sim/test_pack_gauge_mode_scheduler.sv ====
// self-checking bench for the pack gauge mode scheduler
`timescale 1ns/1ps
module test_pack_gauge_mode_scheduler;
	import pgms_pkg::*;
	localparam int NCYC = 50;
	localparam int RESUME_CYC = 25000;
	logic sys_clk_i = 0, rst_b_i = 0, attach = 1, bus_clock_pin_i, bus_data_pin_i;
	logic shutdown_req_i = 0, sleep_req_i = 0, current_flow_i = 0, fault_i = 0;
	logic pf_active_i = 0, master_en_i = 0, pec_en_i = 0;
	logic [31:0] sleep_interval_i = '0;
	logic [63:0] cell_raw_i = '0, cell_mv_o, e64;
	logic [15:0] cell_gain_i = '0, cell_offset_i = '0;
	logic [4:0]  temp_enable_i = '0, temp_is_fet_i = '0, permanent_failure_code_i = '0;
	logic [39:0] temp_raw_i = '0, temp_o, e40, m40;
	logic [7:0]  cell_profile_off_i = '0, fet_profile_off_i = '0, capacity_pct_i = '0;
	logic [2:0]  led_count_i = '0;
	logic cycle_strobe_o, low_power_o, cal_busy_o, bus_off_o, bus_ready_o;
	logic master_active_o, pec_active_o, auth_allow_o;
	logic [4:0]  temp_valid_o, temp_fet_o, led_o;
	pgms_mode_t  mode_o;
	int err_total = 0, num_checks = 0, cyc = 0, n, iv;
	always #20 sys_clk_i = ~sys_clk_i;
	pgms_top #(.NORMAL_CYC(NCYC), .BUSOFF_CYC(200), .CAL_CYC(8)) dut
	(
		.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
		.bus_clock_pin_i(bus_clock_pin_i), .bus_data_pin_i(bus_data_pin_i),
		.shutdown_req_i(shutdown_req_i), .sleep_req_i(sleep_req_i), .sleep_interval_i(sleep_interval_i),
		.current_flow_i(current_flow_i), .fault_i(fault_i),
		.cell_raw_i(cell_raw_i), .cell_gain_i(cell_gain_i), .cell_offset_i(cell_offset_i),
		.temp_enable_i(temp_enable_i), .temp_is_fet_i(temp_is_fet_i), .temp_raw_i(temp_raw_i),
		.cell_profile_off_i(cell_profile_off_i), .fet_profile_off_i(fet_profile_off_i),
		.led_count_i(led_count_i), .capacity_pct_i(capacity_pct_i), .pf_active_i(pf_active_i),
		.permanent_failure_code_i(permanent_failure_code_i),
		.master_en_i(master_en_i), .pec_en_i(pec_en_i),
		.cycle_strobe_o(cycle_strobe_o), .low_power_o(low_power_o), .cal_busy_o(cal_busy_o),
		.bus_off_o(bus_off_o), .bus_ready_o(bus_ready_o), .master_active_o(master_active_o),
		.pec_active_o(pec_active_o), .auth_allow_o(auth_allow_o), .mode_o(mode_o),
		.cell_mv_o(cell_mv_o), .temp_o(temp_o), .temp_valid_o(temp_valid_o),
		.temp_fet_o(temp_fet_o), .led_o(led_o)
	);
	pgms_host_model host (.sys_clk_i(sys_clk_i), .attach_i(attach), .bus_clock_o(bus_clock_pin_i),
		.bus_data_o(bus_data_pin_i));
	task tick;
		@(posedge sys_clk_i);
		#2;
	endtask
	task chk(input string nm, input logic [63:0] s, input logic [63:0] e);
		num_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("mismatch %s exp %h seen %h", nm, e, s);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task wait_strobe;
		n = 0;
		do
		begin
			tick;
			n++;
		end
		while (cycle_strobe_o !== 1'b1 && n < 2000);
	endtask
	task wait_mode(input pgms_mode_t m);
		n = 0;
		while (mode_o !== m && n < 30000)
		begin
			tick;
			n++;
		end
	endtask
	// lit segments rounded up, failure code masked to the bar length
	function automatic logic [4:0] led_exp();
		int c, l;
		c = led_count_i < 3 ? 3 : led_count_i > 5 ? 5 : led_count_i;
		l = (capacity_pct_i * c + 99) / 100;
		if (l > c)
			l = c;
		return pf_active_i ? permanent_failure_code_i & 5'((1 << c) - 1) : 5'((1 << l) - 1);
	endfunction
	always @(posedge sys_clk_i)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_total++;
			tally_and_finish;
		end
	end
	initial
	begin
		void'($urandom(29));
		repeat (8) @(posedge sys_clk_i);
		#2 rst_b_i = 1;
		tick;
		chk("mode", mode_o, PGMS_NORMAL);
		wait_strobe;
		for (int i = 0; i < 6; i++)
		begin
			cell_raw_i = {$urandom, $urandom};
			cell_gain_i = 16'($urandom);
			cell_offset_i = 16'($urandom);
			temp_raw_i = {$urandom, 8'($urandom)};
			temp_enable_i = i < 2 ? 5'h1f : 5'($urandom);
			temp_is_fet_i = 5'($urandom);
			cell_profile_off_i = 8'($urandom);
			fet_profile_off_i = 8'($urandom);
			led_count_i = i == 0 ? 3'h5 : i == 1 ? 3'h3 : 3'($urandom);
			capacity_pct_i = i == 0 ? 8'h64 : i == 1 ? 8'h00 : 8'($urandom_range(100));
			pf_active_i = i > 3;
			permanent_failure_code_i = 5'($urandom);
			master_en_i = 1'($urandom);
			pec_en_i = ~master_en_i;
			wait_strobe;
			chk("period", n, NCYC);
			for (int k = 0; k < 4; k++)
				e64[16*k+:16] = 16'((32'(cell_raw_i[16*k+:16]) * cell_gain_i) >> 16) + cell_offset_i;
			for (int k = 0; k < 5; k++)
			begin
				e40[8*k+:8] = temp_raw_i[8*k+:8] + (temp_is_fet_i[k] ? fet_profile_off_i : cell_profile_off_i);
				m40[8*k+:8] = {8{temp_enable_i[k]}};
			end
			chk("cells", cell_mv_o, e64);
			chk("temp", temp_o & m40, e40 & m40);
			chk("tvalid", {temp_valid_o, temp_fet_o}, {temp_enable_i, temp_is_fet_i});
			chk("led", led_o, led_exp());
			chk("opts", {master_active_o, pec_active_o}, {master_en_i, pec_en_i});
			chk("auth", auth_allow_o, 1'b1);
		end
		$display("test readout done");
		iv = $urandom_range(40, 12);
		sleep_interval_i = iv;
		sleep_req_i = 1;
		wait_mode(PGMS_SLEEP);
		wait_strobe;
		wait_strobe;
		chk("sleep period", n, iv);
		current_flow_i = 1;
		sleep_req_i = 0;
		repeat (3) tick;
		chk("wake", mode_o, PGMS_NORMAL);
		current_flow_i = 0;
		$display("test sleep done");
		attach = 0;
		wait_mode(PGMS_CAL);
		chk("cal", mode_o, PGMS_CAL);
		chk("cal busy", cal_busy_o, 1'b1);
		wait_mode(PGMS_SLEEP);
		chk("cal end", mode_o, PGMS_SLEEP);
		wait_mode(PGMS_BUSOFF);
		chk("busoff", bus_off_o, 1'b1);
		chk("busoff ready", {bus_ready_o, auth_allow_o}, 2'h0);
		attach = 1;
		wait_mode(PGMS_SLEEP);
		chk("prior", mode_o, PGMS_SLEEP);
		n = 0;
		while (bus_ready_o !== 1'b1 && n < 26000)
		begin
			tick;
			n++;
		end
		chk("resume", bus_ready_o, 1'b1);
		chk("resume time", n <= RESUME_CYC, 1'b1);
		fault_i = 1;
		repeat (3) tick;
		chk("fault wake", mode_o, PGMS_NORMAL);
		fault_i = 0;
		$display("test bus off done");
		shutdown_req_i = 1;
		wait_mode(PGMS_SHUTDOWN);
		n = 0;
		repeat (300)
		begin
			tick;
			n += int'(cycle_strobe_o);
		end
		chk("quiet", {32'(n), led_o, bus_ready_o, auth_allow_o, master_active_o, pec_active_o}, 64'h0);
		$display("test shutdown done");
		tally_and_finish;
	end
endmodule
